// [core/slg_core.sv]
// What this block does
// - writing 0 to the module reset bit holds the module in reset, 1 releases it.
// - the module reset bit reads 0 while in reset and 1 once released.
// - bits 31 to 1 of the module reset register read zero and ignore writes.
// - bytes move from the transmit buffer into the shifter only while transmit enable is set.
// - bytes written while transmit enable is clear are never sent.
// - clearing transmit enable mid-frame lets the byte and any LIN checksum finish.
// - assembled characters reach the receive buffer only while receive enable is set.
// - bits 13, 12, 11 and 9 of the link control register change only in LIN mode.
// - bits 8, 4 and 3 of the link control register change only in SCI mode.
// - with receive enable clear, completed frames set no flags but the receive shifter keeps assembling.
// - loopback feeds the transmit line to the receiver and holds the transmit pin high.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module slg_core (
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   input  wire logic               clk_en,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic [31:0]             reg_rdata,
   input  wire logic [slg_pkg::DATA_W-1:0] tx_data,
   input  wire logic               tx_valid,
   output logic                    tx_ready,
   input  wire logic               serial_receive_pin,
   output logic                    serial_transmit_pin
);
   import slg_pkg::*;

   // ****************************************************
   // register file
   // ****************************************************
   logic        mrst_reg, mrst_next;
   logic [31:0] gcr1_reg, gcr1_next, wmask, rdata_reg, rdata_next;
   logic        txen, rxen, loop, lin, mod_on;

   assign mod_on = mrst_reg;
   assign txen   = gcr1_reg[BIT_TXEN];
   assign rxen   = gcr1_reg[BIT_RXEN];
   assign loop   = gcr1_reg[BIT_LOOP];
   assign lin    = gcr1_reg[BIT_LINMODE];

   // transmit and receive datapath state
   slg_tx_state_t tx_state, tx_state_next;
   slg_rx_state_t rx_state, rx_state_next;
   logic [7:0] tx_sh_reg, tx_sh_next, sum_reg, sum_next;
   logic [3:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
   logic [2:0] tx_bit_reg, tx_bit_next, rx_bit_reg, rx_bit_next;
   logic       line_reg, line_next, cks_reg, cks_next;
   logic [7:0] rx_sh_reg, rx_sh_next, rbuf_reg, rbuf_next;
   logic       rxfull_reg, rxfull_next, ferr_reg, ferr_next;
   logic [8:0] sum_add;
   logic       f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [7:0] f_out_data;
   logic       load_cks, rx_in, rx_done, rbuf_rd, ferr_clr;

   always_comb begin
      wmask = GCR1_PLAIN_MASK | (lin ? GCR1_LIN_MASK : GCR1_SCI_MASK);
      mrst_next  = mrst_reg;
      gcr1_next  = gcr1_reg;
      rdata_next = 32'h0;
      if (reg_wr && reg_addr == ADDR_RST) begin
         mrst_next = reg_wdata[BIT_RESET];
      end
      if (reg_wr && reg_addr == ADDR_GCR1) begin
         gcr1_next = (gcr1_reg & ~wmask) | (reg_wdata & wmask);
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_RST:  rdata_next = {31'h0, mrst_reg};
            ADDR_GCR1: rdata_next = gcr1_reg;
            ADDR_RBUF: rdata_next = {24'h0, rbuf_reg};
            ADDR_STAT: rdata_next = {28'h0, cks_reg,
                                     tx_state != TX_IDLE, ferr_reg,
                                     rxfull_reg};
            default:   rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mrst_reg  <= RST_RESET;
         gcr1_reg  <= GCR1_RESET;
         rdata_reg <= 32'h0;
      end else if (clk_en) begin
         mrst_reg  <= mrst_next;
         gcr1_reg  <= gcr1_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign rbuf_rd   = reg_rd && reg_addr == ADDR_RBUF;
   assign ferr_clr  = reg_wr && reg_addr == ADDR_STAT && reg_wdata[STAT_FERR];

   // ****************************************************
   // transmit buffer
   // ****************************************************
   assign f_in_valid = tx_valid && txen && mod_on;
   assign tx_ready   = f_in_ready || !(txen && mod_on);
   assign f_out_ready = tx_state == TX_IDLE && txen && mod_on;
   assign load_cks   = tx_state == TX_IDLE && cks_reg && mod_on
                       && !(txen && f_out_valid);

   slg_fifo #(
      .W(DATA_W),
      .D(FIFO_D)
   ) u_txbuf (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .flush     (!mod_on),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (tx_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // ****************************************************
   // transmit shift register
   // ****************************************************
   assign sum_add = {1'b0, sum_reg} + {1'b0, f_out_data};

   always_comb begin
      tx_state_next = tx_state;
      tx_sh_next    = tx_sh_reg;
      tx_cnt_next   = tx_cnt_reg + 1'b1;
      tx_bit_next   = tx_bit_reg;
      sum_next      = sum_reg;
      cks_next      = cks_reg;
      unique case (tx_state)
         TX_IDLE: begin
            tx_cnt_next = 4'h0;
            if (f_out_ready && f_out_valid) begin
               tx_sh_next    = f_out_data;
               tx_state_next = TX_START;
               if (lin) begin
                  sum_next = sum_add[7:0] + {7'h0, sum_add[8]};
                  cks_next = 1'b1;
               end
            end else if (load_cks) begin
               tx_sh_next    = ~sum_reg;
               tx_state_next = TX_START;
               sum_next      = 8'h0;
               cks_next      = 1'b0;
            end
         end
         TX_START: begin
            if (tx_cnt_reg == BIT_LAST) begin
               tx_state_next = TX_DATA;
               tx_bit_next   = 3'h0;
            end
         end
         TX_DATA: begin
            if (tx_cnt_reg == BIT_LAST) begin
               tx_sh_next  = {1'b0, tx_sh_reg[7:1]};
               tx_bit_next = tx_bit_reg + 1'b1;
               if (tx_bit_reg == LAST_BIT) tx_state_next = TX_STOP;
            end
         end
         TX_STOP: begin
            if (tx_cnt_reg == BIT_LAST) tx_state_next = TX_IDLE;
         end
      endcase
      line_next = tx_state_next == TX_START ? 1'b0 :
                  tx_state_next == TX_DATA  ? tx_sh_next[0] : 1'b1;
      if (!mod_on) begin
         tx_state_next = TX_IDLE;
         tx_cnt_next   = 4'h0;
         tx_bit_next   = 3'h0;
         sum_next      = 8'h0;
         cks_next      = 1'b0;
         line_next     = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_state   <= TX_IDLE;
         tx_sh_reg  <= 8'h0;
         tx_cnt_reg <= 4'h0;
         tx_bit_reg <= 3'h0;
         sum_reg    <= 8'h0;
         cks_reg    <= 1'b0;
         line_reg   <= 1'b1;
      end else if (clk_en) begin
         tx_state   <= tx_state_next;
         tx_sh_reg  <= tx_sh_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_bit_reg <= tx_bit_next;
         sum_reg    <= sum_next;
         cks_reg    <= cks_next;
         line_reg   <= line_next;
      end
   end

   assign serial_transmit_pin = loop ? 1'b1 : line_reg;

   // ****************************************************
   // receive shift register and buffer
   // ****************************************************
   assign rx_in   = loop ? line_reg : serial_receive_pin;
   assign rx_done = rx_state == RX_STOP && rx_cnt_reg == BIT_LAST;

   always_comb begin
      rx_state_next = rx_state;
      rx_cnt_next   = rx_cnt_reg + 1'b1;
      rx_bit_next   = rx_bit_reg;
      rx_sh_next    = rx_sh_reg;
      rbuf_next     = rbuf_reg;
      rxfull_next   = rxfull_reg && !rbuf_rd;
      ferr_next     = ferr_reg && !ferr_clr;
      unique case (rx_state)
         RX_IDLE: begin
            rx_cnt_next = 4'h0;
            if (!rx_in) rx_state_next = RX_START;
         end
         RX_START: begin
            if (rx_cnt_reg == HALF_LAST) begin
               rx_cnt_next   = 4'h0;
               rx_bit_next   = 3'h0;
               rx_state_next = rx_in ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_cnt_reg == BIT_LAST) begin
               rx_sh_next  = {rx_in, rx_sh_reg[7:1]};
               rx_bit_next = rx_bit_reg + 1'b1;
               if (rx_bit_reg == LAST_BIT) rx_state_next = RX_STOP;
            end
         end
         RX_STOP: begin
            if (rx_done) begin
               rx_state_next = RX_IDLE;
               if (rxen) begin
                  rbuf_next   = rx_sh_reg;
                  rxfull_next = 1'b1;
                  if (!rx_in) ferr_next = 1'b1;
               end
            end
         end
      endcase
      if (!mod_on) begin
         rx_state_next = RX_IDLE;
         rx_cnt_next   = 4'h0;
         rx_bit_next   = 3'h0;
         rxfull_next   = 1'b0;
         ferr_next     = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_state   <= RX_IDLE;
         rx_cnt_reg <= 4'h0;
         rx_bit_reg <= 3'h0;
         rx_sh_reg  <= 8'h0;
         rbuf_reg   <= 8'h0;
         rxfull_reg <= 1'b0;
         ferr_reg   <= 1'b0;
      end else if (clk_en) begin
         rx_state   <= rx_state_next;
         rx_cnt_reg <= rx_cnt_next;
         rx_bit_reg <= rx_bit_next;
         rx_sh_reg  <= rx_sh_next;
         rbuf_reg   <= rbuf_next;
         rxfull_reg <= rxfull_next;
         ferr_reg   <= ferr_next;
      end
   end

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_reset_write: assert property (
      reg_wr && clk_en && reg_addr == ADDR_RST
      |=> mrst_reg == $past(reg_wdata[0]))
      else $error("module reset bit did not take written value");
   a_reset_read: assert property (
      reg_rd && clk_en && reg_addr == ADDR_RST
      |=> reg_rdata[0] == $past(mrst_reg))
      else $error("module reset readback wrong");
   a_reset_upper: assert property (
      reg_rd && clk_en && reg_addr == ADDR_RST |=> reg_rdata[31:1] == '0)
      else $error("reserved reset register bits not zero");
   a_tx_gate: assert property (
      clk_en && mod_on && tx_state == TX_IDLE && !txen && !cks_reg
      |=> tx_state == TX_IDLE)
      else $error("buffer moved to shifter while disabled");
   a_tx_drop: assert property (
      clk_en && mod_on && !txen && !f_out_valid |=> !f_out_valid)
      else $error("byte accepted while transmit disabled");
   a_tx_finish: assert property (
      clk_en && mod_on && tx_state == TX_DATA && tx_cnt_reg != BIT_LAST
      |=> tx_state == TX_DATA && tx_cnt_reg == $past(tx_cnt_reg) + 4'h1)
      else $error("frame cut short");
   a_rx_block: assert property (
      clk_en && mod_on && rx_done && !rxen
      |=> rbuf_reg == $past(rbuf_reg)
          && rxfull_reg == ($past(rxfull_reg) && !$past(rbuf_rd)))
      else $error("receive buffer updated while disabled");
   a_lin_only: assert property (
      clk_en && !lin |=> gcr1_reg[13:11] == $past(gcr1_reg[13:11])
                         && gcr1_reg[9] == $past(gcr1_reg[9]))
      else $error("lin-only field changed in sci mode");
   a_sci_only: assert property (
      clk_en && lin |=> gcr1_reg[8] == $past(gcr1_reg[8])
                        && gcr1_reg[4:3] == $past(gcr1_reg[4:3]))
      else $error("sci-only field changed in lin mode");
   a_rx_assemble: assert property (
      clk_en && mod_on && rx_state == RX_DATA && rx_cnt_reg == BIT_LAST
      |=> rx_sh_reg[6:0] == $past(rx_sh_reg[7:1]))
      else $error("receive shifter stopped assembling");
   a_loop_pin: assert property (
      loop |-> serial_transmit_pin && rx_in == line_reg)
      else $error("loopback routing wrong");
   a_loop_route: assert property (
      clk_en && mod_on && loop && rx_state == RX_IDLE
      |=> (rx_state == RX_START) == !$past(line_reg))
      else $error("looped line not seen by receiver");
   a_reset_hold: assert property (
      clk_en && !mod_on |=> tx_state == TX_IDLE && rx_state == RX_IDLE
                            && !rxfull_reg && !cks_reg && !ferr_reg)
      else $error("state not held during module reset");

   c_tx_frame:  cover property (tx_state == TX_STOP ##1 tx_state == TX_IDLE);
   c_rx_store:  cover property (rx_done && rxen && clk_en ##1 rxfull_reg);
   c_checksum:  cover property (load_cks && clk_en);
   c_buf_full:  cover property (tx_valid && txen && !f_in_ready);

endmodule

// [core/slg_pkg.sv]
package slg_pkg;

   // ****************************************************
   // register offsets (byte addresses)
   // ****************************************************
   localparam logic [7:0] ADDR_RST  = 8'h00;
   localparam logic [7:0] ADDR_GCR1 = 8'h04;
   localparam logic [7:0] ADDR_RBUF = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;

   // ****************************************************
   // field positions
   // ****************************************************
   localparam int BIT_RESET   = 0;
   localparam int BIT_TXEN    = 25;
   localparam int BIT_RXEN    = 24;
   localparam int BIT_LOOP    = 16;
   localparam int BIT_LINMODE = 6;
   localparam int STAT_RXFULL = 0;
   localparam int STAT_FERR   = 1;
   localparam int STAT_TXBUSY = 2;
   localparam int STAT_CKSPND = 3;

   // ****************************************************
   // write masks and reset values
   // ****************************************************
   localparam logic [31:0] GCR1_PLAIN_MASK = 32'h0303_04e7;
   localparam logic [31:0] GCR1_LIN_MASK   = 32'h0000_3a00;
   localparam logic [31:0] GCR1_SCI_MASK   = 32'h0000_0118;
   localparam logic [31:0] GCR1_RESET      = 32'h0000_0000;
   localparam logic        RST_RESET       = 1'h0;

   // ****************************************************
   // timing counts and sizes
   // ****************************************************
   localparam logic [3:0] BIT_LAST  = 4'hf;
   localparam logic [3:0] HALF_LAST = 4'h7;
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam int         DATA_W    = 8;
   localparam int         FIFO_D    = 8;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'h0,
      TX_START = 2'h1,
      TX_DATA  = 2'h3,
      TX_STOP  = 2'h2
   } slg_tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_START = 2'h1,
      RX_DATA  = 2'h3,
      RX_STOP  = 2'h2
   } slg_rx_state_t;

endpackage

// [core/slg_fifo.sv]
`timescale 1ns/1ps
module slg_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   input  wire logic         clk_en,
   input  wire logic         flush,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]   cnt_reg, cnt_next;
   logic          push, pop;

   assign in_ready  = cnt_reg != FULL_CNT;
   assign out_valid = cnt_reg != '0;
   assign out_data  = mem[rd_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      cnt_next = cnt_reg;
      if (flush) begin
         wr_next  = '0;
         rd_next  = '0;
         cnt_next = '0;
      end else begin
         if (push) wr_next = wr_reg + 1'b1;
         if (pop) rd_next = rd_reg + 1'b1;
         if (push && !pop) cnt_next = cnt_reg + 1'b1;
         if (pop && !push) cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else if (clk_en) begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // storage holds no reset; entries are only read once written
   always_ff @(posedge ref_clk) begin
      if (clk_en && push && !flush) mem[wr_reg] <= in_data;
   end

endmodule

// [tb/slg_node.sv]
`timescale 1ns/1ps
module slg_node (
   input  wire logic ref_clk,
   input  wire logic line_in,
   output logic      line_out
);
   // ****************************************************
   // far-side serial node: decodes frames, sends on demand
   // ****************************************************
   logic [7:0] got_q[$];
   logic [7:0] shift_byte;
   logic       prev_level;

   // frame: start 0, 8 data bits lsb first, stop 1, 16 cycles a bit
   task automatic send(input logic [7:0] b, input int gap);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      repeat (gap) @(posedge ref_clk);
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         line_out <= frame[i];
         repeat (15) @(posedge ref_clk);
      end
   endtask

   // decoder samples each bit at its middle
   initial begin
      line_out = 1'b1;
      prev_level = 1'b1;
      forever begin
         @(posedge ref_clk);
         if (prev_level && line_in === 1'b0) begin
            repeat (8) @(posedge ref_clk);
            if (line_in === 1'b0) begin
               for (int i = 0; i < 8; i++) begin
                  repeat (16) @(posedge ref_clk);
                  shift_byte[i] = line_in;
               end
               repeat (16) @(posedge ref_clk);
               got_q.push_back(shift_byte);
            end
         end
         prev_level = (line_in === 1'b1);
      end
   end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import slg_pkg::*;
   // ****************************************************
   // signals
   // ****************************************************
   logic        ref_clk;
   logic        rst_b;
   logic        clk_en;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [7:0]  tx_data;
   logic        tx_valid;
   logic        tx_ready;
   logic        rx_line;
   logic        tx_line;
   int          miscompares;
   int          num_checks;
   int          cycles;
   int          low_cycles;
   int          n;
   logic        acc;
   logic [31:0] seed;
   logic [31:0] gcr;
   logic [31:0] wv;
   logic [7:0]  b;
   logic [7:0]  sent_q[$];
   localparam logic [31:0] TXEN = 32'h0200_0000;
   localparam logic [31:0] RXEN = 32'h0100_0000;
   localparam logic [31:0] LOOP = 32'h0001_0000;
   localparam logic [31:0] LIN  = 32'h0000_0040;

   slg_core DUT (
      .ref_clk             (ref_clk),
      .rst_b               (rst_b),
      .clk_en              (clk_en),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_rdata           (reg_rdata),
      .tx_data             (tx_data),
      .tx_valid            (tx_valid),
      .tx_ready            (tx_ready),
      .serial_receive_pin  (rx_line),
      .serial_transmit_pin (tx_line)
   );

   slg_node u_node (
      .ref_clk  (ref_clk),
      .line_in  (tx_line),
      .line_out (rx_line)
   );

   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // mode is judged on the value before the write
   function automatic logic [31:0] gcr_exp(input logic [31:0] old,
                                           input logic [31:0] w);
      logic [31:0] m;
      m = GCR1_PLAIN_MASK | (old[BIT_LINMODE] ? GCR1_LIN_MASK : GCR1_SCI_MASK);
      return (w & m) | (old & ~m);
   endfunction

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      check(what, exp, reg_rdata);
   endtask

   task automatic push(input logic [7:0] d, output logic ok);
      @(posedge ref_clk);
      tx_valid <= 1'b1;
      tx_data  <= d;
      @(negedge ref_clk);
      ok = tx_ready;
      @(posedge ref_clk);
      tx_valid <= 1'b0;
   endtask

   task automatic wait_frames(input int cnt);
      int k;
      k = 0;
      while (u_node.got_q.size() < cnt && k < 4000) begin
         @(posedge ref_clk);
         k++;
      end
      if (k == 4000) begin
         miscompares++;
         $display("ERROR frames expected %0d seen %0d", cnt,
                  u_node.got_q.size());
      end
   endtask

   // ****************************************************
   // clock, watchdog, transmit pin monitor
   // ****************************************************
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (tx_line === 1'b0) begin
         low_cycles <= low_cycles + 1;
      end
      if (cycles == 40000) begin
         miscompares++;
         end_of_test();
      end
   end

   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      miscompares = 0;
      num_checks = 0;
      cycles = 0;
      low_cycles = 0;
      seed = 32'hdd7a;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd_chk("module reset bit", ADDR_RST, 32'h0);
      rd_chk("link control", ADDR_GCR1, GCR1_RESET);
      wr(ADDR_GCR1, TXEN);
      gcr = gcr_exp(GCR1_RESET, TXEN);
      push(8'h5a, acc);
      check("tx_ready held in reset", 1'b1, acc);
      repeat (250) @(posedge ref_clk);
      check("frames in reset", 0, u_node.got_q.size());
      wr(ADDR_RST, 32'hffff_ffff);
      rd_chk("reset released", ADDR_RST, 32'h1);
      wr(ADDR_RST, 32'h0);
      rd_chk("reset entered", ADDR_RST, 32'h0);
      wr(ADDR_RST, 32'h1);
      rd_chk("unmapped", 8'h10, 32'h0);
      for (int i = 0; i < 28; i++) begin
         seed = lfsr(seed);
         wv = (i < 2) ? 32'hffff_ffff : (i < 4) ? 32'h0 : seed;
         wr(ADDR_GCR1, wv);
         gcr = gcr_exp(gcr, wv);
         rd_chk("link control", ADDR_GCR1, gcr);
      end
      wr(ADDR_GCR1, 32'h0);
      wr(ADDR_GCR1, 32'h0);
      push(8'h33, acc);
      check("dropped byte taken", 1'b1, acc);
      wr(ADDR_GCR1, TXEN);
      repeat (400) @(posedge ref_clk);
      check("stale byte sent", 0, u_node.got_q.size());
      n = 0;
      acc = 1'b1;
      while (acc && n < 12) begin
         seed = lfsr(seed);
         push(seed[7:0], acc);
         if (acc) begin
            sent_q.push_back(seed[7:0]);
            n++;
         end
      end
      check("bytes before refusal", FIFO_D + 1, n);
      wait_frames(n);
      check("frames sent", n, u_node.got_q.size());
      for (int i = 0; i < n && i < u_node.got_q.size(); i++) begin
         check("sent byte", sent_q[i], u_node.got_q[i]);
      end
      u_node.got_q.delete();
      wr(ADDR_GCR1, TXEN | LIN);
      b = seed[15:8];
      push(b, acc);
      repeat (40) @(posedge ref_clk);
      wr(ADDR_GCR1, LIN);
      rd_chk("busy and checksum due", ADDR_STAT, 32'h0000_000c);
      wait_frames(2);
      check("frames after disable", 2, u_node.got_q.size());
      check("byte after disable", b, u_node.got_q[0]);
      check("checksum byte", {24'h0, ~b}, u_node.got_q[1]);
      wr(ADDR_GCR1, 32'h0);
      wr(ADDR_GCR1, RXEN);
      seed = lfsr(seed);
      b = seed[7:0];
      u_node.send(b, int'(seed[11:8]));
      rd_chk("rx full", ADDR_STAT, 32'h1);
      rd_chk("receive buffer", ADDR_RBUF, {24'h0, b});
      rd_chk("rx full cleared", ADDR_STAT, 32'h0);
      wr(ADDR_GCR1, 32'h0);
      u_node.send(~b, 0);
      rd_chk("flags with rx off", ADDR_STAT, 32'h0);
      rd_chk("buffer with rx off", ADDR_RBUF, {24'h0, b});
      u_node.got_q.delete();
      wr(ADDR_GCR1, TXEN | RXEN | LOOP);
      low_cycles = 0;
      push(8'hc6, acc);
      repeat (200) @(posedge ref_clk);
      check("pin low in loopback", 0, low_cycles);
      check("frames seen outside", 0, u_node.got_q.size());
      rd_chk("looped byte", ADDR_RBUF, 32'h0000_00c6);
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(ADDR_RST, 32'h0);
      clk_en <= 1'b1;
      rd_chk("write while frozen", ADDR_RST, 32'h1);
      end_of_test();
   end
endmodule
